// ### verilog/ovlc_pkg.sv
// Package for the output voltage limit command bank: command codes,
// paged slot layout, reset values, field encodings and timing counts.
// Assumes a 25 MHz core clock and a two-channel (two-page) device.
package ovlc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int CLK_HZ          = 25_000_000;
	localparam int ADC_SCAN_MS     = 90;
	localparam int ADC_SCAN_CYC    = ADC_SCAN_MS * (CLK_HZ / 1000);
	localparam int OV_SETTLE_MS    = 10;
	localparam int OV_SETTLE_CYC   = (OV_SETTLE_MS * (CLK_HZ / 1000) + 0);
	localparam int SLEW_STEP_NS    = 1000;
	localparam int SLEW_STEP_CYC   = (SLEW_STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	////////////////////////////////////////////////////////////////////////
	// Geometry
	localparam int NPAGE = 2;
	localparam int NSLOT = 9;

	typedef logic [15:0]               ovlc_word_t;
	typedef logic [3:0]                ovlc_slot_t;
	typedef ovlc_word_t [NSLOT-1:0]    ovlc_page_t;
	typedef ovlc_page_t [NPAGE-1:0]    ovlc_bank_t;

	////////////////////////////////////////////////////////////////////////
	// Command codes
	localparam logic [7:0] CODE_FORMAT_EXP     = 8'h20;
	localparam logic [7:0] CODE_NOMINAL        = 8'h21;
	localparam logic [7:0] CODE_CEILING        = 8'h24;
	localparam logic [7:0] CODE_MARGIN_HIGH    = 8'h25;
	localparam logic [7:0] CODE_MARGIN_LOW     = 8'h26;
	localparam logic [7:0] CODE_OV_FAULT       = 8'h40;
	localparam logic [7:0] CODE_OV_WARN        = 8'h42;
	localparam logic [7:0] CODE_UV_WARN        = 8'h43;
	localparam logic [7:0] CODE_UV_FAULT       = 8'h44;
	localparam logic [7:0] CODE_ABS_MAX        = 8'ha5;
	localparam logic [7:0] CODE_IIN_OFFSET     = 8'he9;
	localparam logic [7:0] CODE_TURN_ON        = 8'h35;
	localparam logic [7:0] CODE_TURN_OFF       = 8'h36;

	////////////////////////////////////////////////////////////////////////
	// Paged slot indices
	localparam ovlc_slot_t SLOT_NOMINAL     = 4'h0;
	localparam ovlc_slot_t SLOT_CEILING     = 4'h1;
	localparam ovlc_slot_t SLOT_MARGIN_HIGH = 4'h2;
	localparam ovlc_slot_t SLOT_MARGIN_LOW  = 4'h3;
	localparam ovlc_slot_t SLOT_OV_FAULT    = 4'h4;
	localparam ovlc_slot_t SLOT_OV_WARN     = 4'h5;
	localparam ovlc_slot_t SLOT_UV_WARN     = 4'h6;
	localparam ovlc_slot_t SLOT_UV_FAULT    = 4'h7;
	localparam ovlc_slot_t SLOT_IIN_OFFSET  = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// Reset values and fixed absolute maximum words
	localparam logic [7:0] RST_FORMAT_EXP   = 8'h14;
	localparam ovlc_page_t RST_PAGE = '{
		16'h8be7, 16'h0e66, 16'h0ecd, 16'h1133, 16'h119a,
		16'h0f33, 16'h10cd, 16'h599a, 16'h1000};
	localparam ovlc_word_t RST_TURN_ON      = 16'hcac0;
	localparam ovlc_word_t RST_TURN_OFF     = 16'hcaa0;
	localparam ovlc_word_t ABS_MAX_HIGH_RNG = 16'h5b34;
	localparam ovlc_word_t ABS_MAX_LOW_RNG  = 16'h2c00;

	////////////////////////////////////////////////////////////////////////
	// Field positions and encodings
	localparam int FMT_MODE_LSB      = 5;
	localparam int L11_MANT_MSB      = 10;
	localparam int MFR_BUSY_A_BIT    = 5;
	localparam int MFR_BUSY_B_BIT    = 6;
	localparam logic [1:0] MARGIN_NONE = 2'h0;
	localparam logic [1:0] MARGIN_HIGH = 2'h1;
	localparam logic [1:0] MARGIN_LOW  = 2'h2;
	localparam logic [1:0] PH_OFF    = 2'h0;
	localparam logic [1:0] PH_RISE   = 2'h1;
	localparam logic [1:0] PH_ACTIVE = 2'h2;
	localparam logic [1:0] PH_FALL   = 2'h3;

	typedef enum logic [1:0] {
		CONV_OFF = 2'b01,
		CONV_ON  = 2'b10
	} ovlc_conv_e;

	typedef struct packed {
		logic       write;
		logic [7:0] code;
		logic       page;
		ovlc_word_t data;
	} ovlc_cmd_s;

	typedef struct packed {
		logic       valid;
		logic       nack;
		ovlc_word_t data;
	} ovlc_rsp_s;

	typedef struct packed {
		logic ov_fault;
		logic uv_fault;
		logic ov_warn;
		logic uv_warn;
	} ovlc_status_s;

	// Maps a paged command code to its slot; bit 4 flags a hit
	function automatic logic [4:0] ovlc_slot_of(input logic [7:0] code);
		case (code)
			CODE_NOMINAL:     ovlc_slot_of = {1'b1, SLOT_NOMINAL};
			CODE_CEILING:     ovlc_slot_of = {1'b1, SLOT_CEILING};
			CODE_MARGIN_HIGH: ovlc_slot_of = {1'b1, SLOT_MARGIN_HIGH};
			CODE_MARGIN_LOW:  ovlc_slot_of = {1'b1, SLOT_MARGIN_LOW};
			CODE_OV_FAULT:    ovlc_slot_of = {1'b1, SLOT_OV_FAULT};
			CODE_OV_WARN:     ovlc_slot_of = {1'b1, SLOT_OV_WARN};
			CODE_UV_WARN:     ovlc_slot_of = {1'b1, SLOT_UV_WARN};
			CODE_UV_FAULT:    ovlc_slot_of = {1'b1, SLOT_UV_FAULT};
			CODE_IIN_OFFSET:  ovlc_slot_of = {1'b1, SLOT_IIN_OFFSET};
			default:          ovlc_slot_of = 5'h00;
		endcase
	endfunction

endpackage

// ### verilog/ovlc_page_bank.sv
// Paged word store for the per-channel output commands.
// Assumes the caller has already clamped and qualified each write.
module ovlc_page_bank
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Write port
	input  wire logic              wr_en_i,
	input  wire logic              wr_page_i,
	input  wire ovlc_pkg::ovlc_slot_t wr_slot_i,
	input  wire ovlc_pkg::ovlc_word_t wr_data_i,
	// Read port, one cycle latency
	input  wire logic              rd_page_i,
	input  wire ovlc_pkg::ovlc_slot_t rd_slot_i,
	output ovlc_pkg::ovlc_word_t   rd_data_o,
	// All words, for the limit logic
	output ovlc_pkg::ovlc_bank_t   words_o
);
	import ovlc_pkg::*;

	ovlc_bank_t words;
	ovlc_bank_t next_words;
	ovlc_word_t next_rd_data;

	always_comb
	begin
		next_words = words;
		if (wr_en_i && (int'(wr_slot_i) < NSLOT))
		begin
			next_words[wr_page_i][wr_slot_i] = wr_data_i;
		end
		next_rd_data = (int'(rd_slot_i) < NSLOT) ? words[rd_page_i][rd_slot_i] : 16'h0000;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			words     <= {NPAGE{RST_PAGE}};
			rd_data_o <= 16'h0000;
		end
		else
		begin
			words     <= next_words;
			rd_data_o <= next_rd_data;
		end
	end

	assign words_o = words;

endmodule

// ### verilog/ovlc_core.sv
// Output voltage limit command bank of a two-channel step-down module.
// Assumes a command layer outside decodes the serial protocol into one
// command per cycle, and that sequencer and operation inputs share clk_i.
// What this block does
// - Start conversion when input reaches turn-on
// - Stop conversion when input falls to turn-off
// - Read-only format byte: linear mode, exponent
// - Output words are unsigned scaled mantissas
// - Set point clamped to ceiling; ceiling max 5.7V
// - Overvoltage fault when sense exceeds limit
// - Busy recalculating drives status bits 5,6 low
// - Pulldown response: no fault pin, gates pulled
// - Overvoltage warning sets status and alert
// - Undervoltage warning sets status and alert
// - Warnings reported within measurement scan period
// - Undervoltage fault when sense below limit
// - Set point changes ignored during rise/fall
// - Settled output slews to new set point
// - Absolute maximum follows range bit
// - Set point over maximum: logic fault, clamp
// - Quiescent offset added to reported input current
module ovlc_core
#(
	parameter int ADC_SCAN_CYCLES  = ovlc_pkg::ADC_SCAN_CYC,
	parameter int OV_SETTLE_CYCLES = ovlc_pkg::OV_SETTLE_CYC
)
(
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// Command port
	input  wire logic                  cmd_valid_i,
	input  wire ovlc_pkg::ovlc_cmd_s   cmd_i,
	output ovlc_pkg::ovlc_rsp_s        rsp_o,
	// Operation and sequencing, same clock
	input  wire logic [1:0][1:0]       op_margin_i,
	input  wire logic [1:0][1:0]       seq_phase_i,
	input  wire logic                  clear_faults_i,
	input  wire logic [1:0][1:0]       warn_mask_i,
	// Measurements and straps, asynchronous
	input  wire logic [15:0]           input_supply_sense_i,
	input  wire logic [1:0][15:0]      vout_sense_i,
	input  wire logic [1:0][15:0]      vout_readback_i,
	input  wire logic [1:0][15:0]      iin_measured_i,
	input  wire logic [1:0]            pwm_range_low_i,
	input  wire logic [1:0]            overvoltage_pulldown_response_i,
	// Power stage
	output logic                       conv_enable_o,
	output ovlc_pkg::ovlc_word_t [1:0] vout_target_o,
	output logic [1:0]                 top_gate_drive_o,
	output logic [1:0]                 bottom_gate_drive_o,
	// Status and reporting
	output ovlc_pkg::ovlc_status_s [1:0] status_vout_o,
	output logic                       status_byte_none_o,
	output logic                       status_word_vout_o,
	output logic                       cml_fault_o,
	output logic [7:0]                 common_manufacturer_status_o,
	output ovlc_pkg::ovlc_word_t [1:0] iin_report_o,
	output logic                       alert_oe_o,
	output logic                       fault_gpio_oe_o
);
	import ovlc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers on all measurement pins
	localparam int SW = 16 + 3 * 32 + 4;

	logic [SW-1:0] pin_raw;
	logic [SW-1:0] pin_meta;
	logic [SW-1:0] pin_sync;

	assign pin_raw = {input_supply_sense_i, vout_sense_i, vout_readback_i, iin_measured_i,
		pwm_range_low_i, overvoltage_pulldown_response_i};

	genvar gi;
	generate
		for (gi = 0; gi < SW; gi++)
		begin : g_sync
			always_ff @(posedge clk_i)
			begin
				pin_meta[gi] <= pin_raw[gi];
				pin_sync[gi] <= pin_meta[gi];
			end
		end
	endgenerate

	ovlc_word_t       vin_s;
	ovlc_word_t [1:0] sense_s;
	ovlc_word_t [1:0] readback_s;
	ovlc_word_t [1:0] iin_s;
	logic [1:0]       range_low_s;
	logic [1:0]       pulldown_s;

	assign {vin_s, sense_s, readback_s, iin_s, range_low_s, pulldown_s} = pin_sync;

	////////////////////////////////////////////////////////////////////////
	// Paged store
	logic        bank_wr;
	ovlc_slot_t  bank_wr_slot;
	ovlc_word_t  bank_wr_data;
	ovlc_word_t  bank_rd_data;
	ovlc_bank_t  bank;
	logic [4:0]  hit;

	assign hit = ovlc_slot_of(cmd_i.code);

	ovlc_page_bank u_bank
	(
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wr_en_i   (bank_wr),
		.wr_page_i (cmd_i.page),
		.wr_slot_i (bank_wr_slot),
		.wr_data_i (bank_wr_data),
		.rd_page_i (cmd_i.page),
		.rd_slot_i (hit[3:0]),
		.rd_data_o (bank_rd_data),
		.words_o   (bank)
	);

	////////////////////////////////////////////////////////////////////////
	// State
	ovlc_conv_e             conv,         next_conv;
	ovlc_word_t             turn_on,      next_turn_on;
	ovlc_word_t             turn_off,     next_turn_off;
	ovlc_word_t [1:0]       target,       next_target;
	ovlc_status_s [1:0]     status,       next_status;
	logic                   cml,          next_cml;
	logic [21:0]            scan_cnt,     next_scan_cnt;
	logic [21:0]            busy_cnt,     next_busy_cnt;
	logic [7:0]             slew_cnt,     next_slew_cnt;
	logic                   rsp_valid,    next_rsp_valid;
	logic                   rsp_nack,     next_rsp_nack;
	logic                   rsp_bank,     next_rsp_bank;
	ovlc_word_t             rsp_local,    next_rsp_local;

	ovlc_word_t [1:0]       abs_max;
	ovlc_word_t [1:0]       want;
	logic                   scan_tick;
	logic                   slew_tick;
	logic                   any_active;
	logic                   is_setpoint;

	always_comb
	begin
		for (int c = 0; c < NPAGE; c++)
		begin
			abs_max[c] = range_low_s[c] ? ABS_MAX_LOW_RNG : ABS_MAX_HIGH_RNG;
			case (op_margin_i[c])
				MARGIN_HIGH: want[c] = bank[c][SLOT_MARGIN_HIGH];
				MARGIN_LOW:  want[c] = bank[c][SLOT_MARGIN_LOW];
				default:     want[c] = bank[c][SLOT_NOMINAL];
			endcase
			if (want[c] > bank[c][SLOT_CEILING])
			begin
				want[c] = bank[c][SLOT_CEILING];
			end
		end
	end

	assign scan_tick   = (scan_cnt == 22'(ADC_SCAN_CYCLES - 1));
	assign slew_tick   = (slew_cnt == 8'(SLEW_STEP_CYC - 1));
	assign any_active  = (seq_phase_i[0] != PH_OFF) || (seq_phase_i[1] != PH_OFF);
	assign is_setpoint = (hit[3:0] == SLOT_NOMINAL) || (hit[3:0] == SLOT_MARGIN_HIGH)
		|| (hit[3:0] == SLOT_MARGIN_LOW);

	////////////////////////////////////////////////////////////////////////
	// Command handling and limit logic
	always_comb
	begin
		next_conv      = conv;
		next_turn_on   = turn_on;
		next_turn_off  = turn_off;
		next_target    = target;
		next_status    = status;
		next_cml       = cml;
		next_scan_cnt  = scan_tick ? 22'h000000 : scan_cnt + 22'h000001;
		next_slew_cnt  = slew_tick ? 8'h00 : slew_cnt + 8'h01;
		next_busy_cnt  = (busy_cnt != 22'h000000) ? busy_cnt - 22'h000001 : busy_cnt;
		next_rsp_valid = 1'b0;
		next_rsp_nack  = 1'b0;
		next_rsp_bank  = 1'b0;
		next_rsp_local = 16'h0000;
		bank_wr        = 1'b0;
		bank_wr_slot   = hit[3:0];
		bank_wr_data   = cmd_i.data;

		// Unsigned compare of the 11-bit mantissas; both words share one exponent
		case (conv)
			CONV_OFF:
				if (vin_s[L11_MANT_MSB:0] >= turn_on[L11_MANT_MSB:0])
				begin
					next_conv = CONV_ON;
				end
			CONV_ON:
				if (vin_s[L11_MANT_MSB:0] <= turn_off[L11_MANT_MSB:0])
				begin
					next_conv = CONV_OFF;
				end
			default:
				next_conv = CONV_OFF;
		endcase

		if (cmd_valid_i)
		begin
			next_rsp_valid = 1'b1;
			if (cmd_i.write)
			begin
				if (hit[4])
				begin
					bank_wr = 1'b1;
					if (is_setpoint && (cmd_i.data > abs_max[cmd_i.page]))
					begin
						bank_wr_data = abs_max[cmd_i.page];
						next_cml     = 1'b1;
					end
					if ((hit[3:0] == SLOT_CEILING) && (cmd_i.data > ABS_MAX_HIGH_RNG))
					begin
						bank_wr_data = ABS_MAX_HIGH_RNG;
					end
					if ((hit[3:0] == SLOT_OV_FAULT) && any_active)
					begin
						next_busy_cnt = 22'(OV_SETTLE_CYCLES);
					end
				end
				else if (cmd_i.code == CODE_TURN_ON)
				begin
					next_turn_on = cmd_i.data;
				end
				else if (cmd_i.code == CODE_TURN_OFF)
				begin
					next_turn_off = cmd_i.data;
				end
				else
				begin
					next_rsp_nack = 1'b1;
				end
			end
			else
			begin
				next_rsp_bank = hit[4];
				case (cmd_i.code)
					CODE_FORMAT_EXP: next_rsp_local = {8'h00, RST_FORMAT_EXP};
					CODE_ABS_MAX:    next_rsp_local = abs_max[cmd_i.page];
					CODE_TURN_ON:    next_rsp_local = turn_on;
					CODE_TURN_OFF:   next_rsp_local = turn_off;
					default:         next_rsp_nack  = !hit[4];
				endcase
			end
		end

		for (int c = 0; c < NPAGE; c++)
		begin
			// Target held during sequencing ramps, stepped when settled
			case (seq_phase_i[c])
				PH_OFF:
					next_target[c] = want[c];
				PH_ACTIVE:
					if (slew_tick && (target[c] < want[c]))
					begin
						next_target[c] = target[c] + 16'h0001;
					end
					else if (slew_tick && (target[c] > want[c]))
					begin
						next_target[c] = target[c] - 16'h0001;
					end
				default:
					next_target[c] = target[c];
			endcase

			if (clear_faults_i)
			begin
				next_status[c] = '0;
			end
			// Sets are applied after the clear so a same-cycle event wins
			if (sense_s[c] > bank[c][SLOT_OV_FAULT])
			begin
				next_status[c].ov_fault = 1'b1;
			end
			if (sense_s[c] < bank[c][SLOT_UV_FAULT])
			begin
				next_status[c].uv_fault = 1'b1;
			end
			// Warnings use the slow readback scan, so reporting lags by a scan period
			if (scan_tick && (readback_s[c] > bank[c][SLOT_OV_WARN]))
			begin
				next_status[c].ov_warn = 1'b1;
			end
			if (scan_tick && (readback_s[c] < bank[c][SLOT_UV_WARN]))
			begin
				next_status[c].uv_warn = 1'b1;
			end
		end
		if (clear_faults_i)
		begin
			next_cml = 1'b0;
		end
		if (cmd_valid_i && cmd_i.write && hit[4] && is_setpoint
			&& (cmd_i.data > abs_max[cmd_i.page]))
		begin
			next_cml = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			conv      <= CONV_OFF;
			turn_on   <= RST_TURN_ON;
			turn_off  <= RST_TURN_OFF;
			target    <= '0;
			status    <= '0;
			cml       <= 1'b0;
			scan_cnt  <= 22'h000000;
			busy_cnt  <= 22'h000000;
			slew_cnt  <= 8'h00;
			rsp_valid <= 1'b0;
			rsp_nack  <= 1'b0;
			rsp_bank  <= 1'b0;
			rsp_local <= 16'h0000;
		end
		else
		begin
			conv      <= next_conv;
			turn_on   <= next_turn_on;
			turn_off  <= next_turn_off;
			target    <= next_target;
			status    <= next_status;
			cml       <= next_cml;
			scan_cnt  <= next_scan_cnt;
			busy_cnt  <= next_busy_cnt;
			slew_cnt  <= next_slew_cnt;
			rsp_valid <= next_rsp_valid;
			rsp_nack  <= next_rsp_nack;
			rsp_bank  <= next_rsp_bank;
			rsp_local <= next_rsp_local;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	logic [1:0] warn_alert;
	logic [1:0] ov_gpio;

	always_comb
	begin
		for (int c = 0; c < NPAGE; c++)
		begin
			warn_alert[c] = (status[c].ov_warn && !warn_mask_i[c][1])
				|| (status[c].uv_warn && !warn_mask_i[c][0]);
			ov_gpio[c] = status[c].ov_fault && !pulldown_s[c];
			if (status[c].ov_fault)
			begin
				// Pulldown crowbars through the bottom switch; otherwise both off
				top_gate_drive_o[c]    = 1'b0;
				bottom_gate_drive_o[c] = pulldown_s[c];
			end
			else
			begin
				top_gate_drive_o[c]    = (conv == CONV_ON) && (seq_phase_i[c] != PH_OFF);
				bottom_gate_drive_o[c] = (conv == CONV_ON) && (seq_phase_i[c] != PH_OFF);
			end
			iin_report_o[c] = {input_quiescent_exp(c),
				11'(iin_s[c][L11_MANT_MSB:0] + bank[c][SLOT_IIN_OFFSET][L11_MANT_MSB:0])};
		end
	end

	// Exponent of the offset word; measured current is assumed to share it
	function automatic logic [4:0] input_quiescent_exp(input int c);
		input_quiescent_exp = bank[c][SLOT_IIN_OFFSET][15:11];
	endfunction

	assign conv_enable_o      = (conv == CONV_ON);
	assign vout_target_o      = target;
	assign status_vout_o      = status;
	assign status_byte_none_o = (|status[0]) || (|status[1]);
	assign status_word_vout_o = (|status[0]) || (|status[1]);
	assign cml_fault_o        = cml;
	assign alert_oe_o         = |warn_alert;
	assign fault_gpio_oe_o    = |ov_gpio;
	assign common_manufacturer_status_o = (busy_cnt != 22'h000000) ? 8'h00
		: (8'h01 << MFR_BUSY_A_BIT) | (8'h01 << MFR_BUSY_B_BIT);
	assign rsp_o.valid = rsp_valid;
	assign rsp_o.nack  = rsp_nack;
	assign rsp_o.data  = rsp_bank ? bank_rd_data : rsp_local;

endmodule

// ### test/ovlc_core_chk.sv
// Port checker for the output voltage limit command bank.
// Assumes it is bound onto ovlc_core and sees only that module's ports.
module ovlc_core_chk
(
	// Clock and reset
	input wire logic                         clk_i,
	input wire logic                         rst_i,
	// Command port
	input wire logic                         cmd_valid_i,
	input wire ovlc_pkg::ovlc_cmd_s          cmd_i,
	input wire ovlc_pkg::ovlc_rsp_s          rsp_o,
	// Controls
	input wire logic [1:0][1:0]              seq_phase_i,
	input wire logic [1:0][1:0]              warn_mask_i,
	input wire logic [1:0]                   overvoltage_pulldown_response_i,
	// Outputs
	input wire ovlc_pkg::ovlc_word_t [1:0]   vout_target_o,
	input wire logic [1:0]                   top_gate_drive_o,
	input wire logic [1:0]                   bottom_gate_drive_o,
	input wire ovlc_pkg::ovlc_status_s [1:0] status_vout_o,
	input wire logic                         status_byte_none_o,
	input wire logic                         status_word_vout_o,
	input wire logic                         cml_fault_o,
	input wire logic [7:0]                   common_manufacturer_status_o,
	input wire logic                         alert_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import ovlc_pkg::*;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_ro_write_nack: assert property (
		cmd_valid_i && cmd_i.write && (cmd_i.code == CODE_FORMAT_EXP || cmd_i.code == CODE_ABS_MAX)
		|=> rsp_o.valid && rsp_o.nack) else $error("read-only write not refused");
	a_format_read: assert property (
		cmd_valid_i && !cmd_i.write && cmd_i.code == CODE_FORMAT_EXP
		|=> rsp_o.valid && !rsp_o.nack && rsp_o.data == 16'h0014) else $error("format byte wrong");
	a_target_bound: assert property (
		vout_target_o[0] <= 16'h5b34 && vout_target_o[1] <= 16'h5b34) else $error("target too high");
	a_cml_on_clamp: assert property (
		cmd_valid_i && cmd_i.write && cmd_i.code == CODE_NOMINAL && cmd_i.data > 16'h5b34
		|=> cml_fault_o) else $error("no logic fault on clamp");
	a_busy_after_ov: assert property (
		cmd_valid_i && cmd_i.write && cmd_i.code == CODE_OV_FAULT
		&& seq_phase_i[0] != PH_OFF && seq_phase_i[1] != PH_OFF
		|=> common_manufacturer_status_o[6:5] != 2'b11) else $error("busy not shown");
	a_busy_code: assert property (
		common_manufacturer_status_o == 8'h60 || common_manufacturer_status_o == 8'h00)
		else $error("status code unexpected");
	a_pulldown_gate: assert property (
		status_vout_o[1].ov_fault && overvoltage_pulldown_response_i[1]
		&& $past(overvoltage_pulldown_response_i[1], 3)
		|-> !top_gate_drive_o[1] && bottom_gate_drive_o[1]) else $error("gates not pulled");
	a_summary_bits: assert property (
		(|status_vout_o) |-> status_byte_none_o && status_word_vout_o)
		else $error("summary bits missing");
	a_alert_ov: assert property (
		status_vout_o[0].ov_warn && !warn_mask_i[0][1] |-> ##[0:1] alert_oe_o)
		else $error("alert missing on high warning");
	a_alert_uv: assert property (
		status_vout_o[1].uv_warn && !warn_mask_i[1][0] |-> ##[0:1] alert_oe_o)
		else $error("alert missing on low warning");
endmodule

bind ovlc_core ovlc_core_chk i_ovlc_core_chk (.clk_i(clk_i), .rst_i(rst_i),
	.cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .rsp_o(rsp_o), .seq_phase_i(seq_phase_i),
	.warn_mask_i(warn_mask_i), .overvoltage_pulldown_response_i(overvoltage_pulldown_response_i),
	.vout_target_o(vout_target_o), .top_gate_drive_o(top_gate_drive_o),
	.bottom_gate_drive_o(bottom_gate_drive_o), .status_vout_o(status_vout_o),
	.status_byte_none_o(status_byte_none_o), .status_word_vout_o(status_word_vout_o),
	.cml_fault_o(cml_fault_o), .common_manufacturer_status_o(common_manufacturer_status_o),
	.alert_oe_o(alert_oe_o));

// ### test/ovlc_host_model.sv
// Host side model: issues one command word per request.
// Assumes the bench notes and checks the answers itself.
module ovlc_host_model
(
	// Clock and busy status
	input  wire logic          clk_i,
	input  wire logic [7:0]    mfr_status_i,
	// Command port
	output logic               cmd_valid_o,
	output ovlc_pkg::ovlc_cmd_s cmd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import ovlc_pkg::*;
	initial
	begin
		cmd_valid_o = 1'b0;
		cmd_o = '0;
	end
	task automatic issue(input logic w, input logic [7:0] c, input logic p, input ovlc_word_t d);
		@(posedge clk_i);
		cmd_valid_o <= 1'b1;
		cmd_o <= '{w, c, p, d};
		@(posedge clk_i);
		cmd_valid_o <= 1'b0;
		// Released data is inverted so a stale word never looks valid
		cmd_o.data <= ~d;
	endtask
	// Raising the set point before the new limit is honoured could trip it
	task automatic ov_limit(input logic p, input ovlc_word_t d, output int n);
		issue(1'b1, CODE_OV_FAULT, p, d);
		n = 0;
		do
		begin
			@(negedge clk_i);
			n++;
		end
		while (mfr_status_i[6:5] != 2'b11 && n < 100);
		// Hand back on a rising edge so the bench drives on it
		@(posedge clk_i);
	endtask
endmodule

// ### test/ovlc_core_tb.sv
// Self-checking bench for the output voltage limit command bank.
// Assumes short scan and settle counts; the host model issues commands.
module ovlc_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ovlc_pkg::*;
	localparam int SCAN = 16;
	localparam logic [7:0] RC[13] = '{8'h20, 8'h21, 8'h24, 8'h25, 8'h26, 8'h40, 8'h42,
		8'h43, 8'h44, 8'ha5, 8'he9, 8'h35, 8'h36};
	localparam ovlc_word_t RV[13] = '{16'h0014, 16'h1000, 16'h599a, 16'h10cd, 16'h0f33,
		16'h119a, 16'h1133, 16'h0ecd, 16'h0e66, 16'h5b34, 16'h8be7, 16'hcac0, 16'hcaa0};
	localparam logic [10:0] VM[4] = '{11'h2b0, 11'h2c0, 11'h2b0, 11'h2a0};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cv, conv, sb, sw, cml, alrt, gpio;
	logic clrf = 1'b0;
	logic [1:0][1:0] marg = '0, ph = '0, mask = '0;
	logic [1:0] rng = '0, pd = 2'b10, tg, bg;
	ovlc_cmd_s cmd;
	ovlc_rsp_s rsp;
	ovlc_word_t vin = 16'hc800;
	ovlc_word_t [1:0] vs = {2{16'h1000}}, vr = {2{16'h1000}}, im = '0, tgt, iin;
	ovlc_status_s [1:0] st;
	logic [7:0] mfr;
	logic [10:0] m;
	logic [17:0] note;
	logic [17:0] exp_q[$];
	int n_errors = 0;
	int n_compared = 0;
	int n;

	ovlc_core #(.ADC_SCAN_CYCLES(SCAN), .OV_SETTLE_CYCLES(8)) i_ovlc_core (.clk_i(clk),
		.rst_i(rst), .cmd_valid_i(cv), .cmd_i(cmd), .rsp_o(rsp), .op_margin_i(marg),
		.seq_phase_i(ph), .clear_faults_i(clrf), .warn_mask_i(mask), .input_supply_sense_i(vin),
		.vout_sense_i(vs), .vout_readback_i(vr), .iin_measured_i(im), .pwm_range_low_i(rng),
		.overvoltage_pulldown_response_i(pd), .conv_enable_o(conv), .vout_target_o(tgt),
		.top_gate_drive_o(tg), .bottom_gate_drive_o(bg), .status_vout_o(st),
		.status_byte_none_o(sb), .status_word_vout_o(sw), .cml_fault_o(cml),
		.common_manufacturer_status_o(mfr), .iin_report_o(iin), .alert_oe_o(alrt),
		.fault_gpio_oe_o(gpio));
	ovlc_host_model i_ovlc_host_model (.clk_i(clk), .mfr_status_i(mfr), .cmd_valid_o(cv),
		.cmd_o(cmd));

	always #20 clk = ~clk;

	task automatic chk(input logic [16:0] g, input logic [16:0] e);
		n_compared++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// Note layout: compare data, nack, data
	task automatic rd(input logic [7:0] c, input logic p, input ovlc_word_t d, input logic nk);
		exp_q.push_back({1'b1, nk, d});
		i_ovlc_host_model.issue(1'b0, c, p, 16'h0000);
	endtask
	task automatic wr(input logic [7:0] c, input logic p, input ovlc_word_t d, input logic nk);
		exp_q.push_back({1'b0, nk, 16'h0000});
		i_ovlc_host_model.issue(1'b1, c, p, d);
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic clear_all();
		clrf <= 1'b1;
		step(1);
		clrf <= 1'b0;
	endtask
	task automatic complete_run();
		chk(17'(exp_q.size()), 17'h0);
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(negedge clk)
		if (rsp.valid === 1'b1)
		begin
			note = (exp_q.size() == 0) ? 18'h1ffff : exp_q.pop_front();
			chk({rsp.nack, note[17] ? rsp.data : 16'h0000}, note[16:0]);
		end

	initial
	begin
		#(40 * 20000);
		n_errors++;
		complete_run();
	end

	initial
	begin
		n = $urandom(32'h1dd4);
		step(8);
		rst <= 1'b0;
		step(3);
		for (int k = 0; k < 26; k++)
			rd(RC[k % 13], 1'(k / 13), RV[k % 13], 1'b0);
		rd(8'h99, 1'b0, 16'h0000, 1'b1);
		wr(CODE_FORMAT_EXP, 1'b0, 16'h0015, 1'b1);
		wr(CODE_ABS_MAX, 1'b1, 16'h1111, 1'b1);
		wr(CODE_NOMINAL, 1'b1, 16'h1200, 1'b0);
		rd(CODE_NOMINAL, 1'b1, 16'h1200, 1'b0);
		rd(CODE_NOMINAL, 1'b0, 16'h1000, 1'b0);
		$display("Test done: registers");
		wr(CODE_NOMINAL, 1'b0, 16'h6000, 1'b0);
		rd(CODE_NOMINAL, 1'b0, 16'h5b34, 1'b0);
		step(3);
		chk(17'({cml, tgt[0]}), 17'h1599a);
		clear_all();
		wr(CODE_NOMINAL, 1'b0, 16'h1000, 1'b0);
		step(3);
		chk(17'(cml), 17'h0);
		rng[1] <= 1'b1;
		step(4);
		rd(CODE_ABS_MAX, 1'b1, 16'h2c00, 1'b0);
		rd(CODE_ABS_MAX, 1'b0, 16'h5b34, 1'b0);
		marg[0] <= MARGIN_HIGH;
		step(4);
		chk(17'(tgt[0]), 17'h10cd);
		marg[0] <= MARGIN_LOW;
		step(4);
		chk(17'(tgt[0]), 17'h0f33);
		marg[0] <= MARGIN_NONE;
		ph[1] <= PH_RISE;
		wr(CODE_NOMINAL, 1'b1, 16'h1210, 1'b0);
		step(6);
		chk(17'(tgt[1]), 17'h1200);
		ph[1] <= PH_ACTIVE;
		step(10);
		chk(17'(tgt[1] inside {[16'h1200:16'h1201]}), 17'h1);
		step(16 * 25 + 20);
		chk(17'(tgt[1]), 17'h1210);
		ph[0] <= PH_ACTIVE;
		exp_q.push_back(18'h0);
		i_ovlc_host_model.ov_limit(1'b0, 16'h1180, n);
		chk(17'(n >= 6 && n <= 10), 17'h1);
		ph <= '0;
		$display("Test done: set points");
		for (int k = 0; k < 4; k++)
		begin
			vin <= {5'b11001, VM[k]};
			step(6);
			chk(17'(conv), 17'(k == 1 || k == 2));
		end
		chk(17'(st), 17'h0);
		vr <= {16'h0ecc, 16'h1134};
		step(2 * SCAN + 6);
		chk(17'({st[0].ov_warn, st[1].uv_warn, sb, sw, alrt}), 17'h1f);
		mask <= {2'b01, 2'b10};
		clear_all();
		step(2 * SCAN + 6);
		chk(17'({st[0].ov_warn, st[1].uv_warn, alrt}), 17'h6);
		$display("Test done: warnings");
		vs[1] <= 16'h119a;
		step(5);
		chk(17'(st[1].ov_fault), 17'h0);
		vs[1] <= 16'h119b;
		step(5);
		chk(17'({st[1].ov_fault, tg[1], bg[1], gpio}), 17'ha);
		vs[0] <= 16'h0e65;
		step(5);
		chk(17'(st[0].uv_fault), 17'h1);
		vs[0] <= 16'h1181;
		step(5);
		chk(17'({st[0].ov_fault, gpio}), 17'h3);
		$display("Test done: faults");
		for (int k = 0; k < 4; k++)
		begin
			m = 11'($urandom);
			// Converter is off (input at turn-off, phases off) while offsets are checked
			im[k % 2] <= {5'b10001, m};
			step(5);
			chk(17'(iin[k % 2]), 17'({5'b10001, 11'(m + 11'h3e7)}));
		end
		$display("Test done: input current");
		step(4);
		complete_run();
	end
endmodule
